// [verilog/hbsc_control.sv]
// hbsc_control: spi slave and pin logic of an h-bridge motor driver
// assumes all pins are asynchronous to clk and sclk runs far below clk
//
// Operation
// - wake low: all drivers off, sleep
// - wake high: bridge and interface run normally
// - standby high while wake high: drivers off, standby, not sleep
// - standby low does not inhibit outputs
// - never both switches of one half on
// - each direction input selects the high side (high) or the low side (low) of its half
// - direction change without shoot-through
// - slew follows last programmed slew setting
// - spi slave, daisy-chain on shared select
// - sample mosi falling, change miso rising
// - miso sends msb first
// - after the 16-bit read-back word, echo mosi
// - miso driven only while select low
// - mosi msb first, only while selected
// - select rise commits the shift register on a whole number of words
// - select fall loads previously addressed register
// - fault flag low for unmasked faults only
`timescale 1ns/1ps
module hbsc_control
  import hbsc_pkg::*;
#(
  parameter int FAULT_W = HBSC_FAULT_W,
  parameter int DEAD_CYC = HBSC_DEAD_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // mode pins
  input wire logic wake_input,
  input wire logic standby_request,
  // direction pins
  input wire logic direction_ctrl_a,
  input wire logic direction_ctrl_b,
  // spi pins
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso_o,
  output logic miso_oe,
  // fault sources from the power stage
  input wire logic [FAULT_W-1:0] fault_in,
  // open-drain fault flag
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe,
  // gates of half_bridge_a
  output logic hs_a_on,
  output logic ls_a_on,
  // gates of half_bridge_b
  output logic hs_b_on,
  output logic ls_b_on,
  // mode and slew state
  output logic sleep_o,
  output logic standby_o,
  output logic [HBSC_SLEW_W-1:0] slew_sel_o
);
  ////////////////////////////////////////////////////////////////////////////
  // types and constants

  // all control state of this module
  typedef struct packed
  {
    logic sclk_d;
    logic cs_d;
    logic [HBSC_WORD_W-1:0] sr;
    logic [HBSC_CNT_W-1:0] cnt;
    logic full;
    logic [HBSC_ADDR_W-1:0] prev_addr;
    logic [HBSC_SLEW_W-1:0] slew;
    logic [FAULT_W-1:0] mask;
    logic miso;
    logic miso_oe;
    logic fault_lo;
    logic fault_oe;
    logic sleep;
    logic standby;
  } hbsc_top_st_t;

  // reset image: idle bus, asleep, default slew and mask
  localparam hbsc_top_st_t TOP_RST = '{
    sclk_d: 1'b0,
    cs_d: 1'b1,
    sr: '0,
    cnt: '0,
    full: 1'b0,
    prev_addr: HBSC_ADDR_STATUS,
    slew: HBSC_SLEW_RST,
    mask: FAULT_W'(HBSC_MASK_RST),
    miso: 1'b0,
    miso_oe: 1'b0,
    fault_lo: 1'b0,
    fault_oe: 1'b0,
    sleep: 1'b1,
    standby: 1'b0
  };

  // width of the synchronised pin bus
  localparam int PIN_W = 7 + FAULT_W;
  // pins idle: select high, everything else low
  localparam logic [PIN_W-1:0] PIN_RST = PIN_W'(7'h04) << FAULT_W;

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  // registered state and its next value
  hbsc_top_st_t s_r;
  hbsc_top_st_t s_nxt;
  // synchronised pin bus
  logic [PIN_W-1:0] pin_q;
  // synchronised pins, split out
  logic wake_s;
  logic standby_s;
  logic dir_a_s;
  logic dir_b_s;
  logic cs_s;
  logic sclk_s;
  logic mosi_s;
  logic [FAULT_W-1:0] fault_s;
  // edges of the serial pins
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  // bus accepted only while awake and selected
  logic active;
  // word read back from the addressed register
  logic [HBSC_WORD_W-1:0] rd_word;
  // fields of the committed word
  logic [HBSC_ADDR_W-1:0] cmd_addr;
  logic cmd_wr;
  // bridge may be driven
  logic bridge_en;
  // per half-bridge request and gates
  logic [1:0] dir_s;
  logic [1:0] hs_on;
  logic [1:0] ls_on;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  // every pin passes two flops before use
  hbsc_sync #(
    .W(PIN_W),
    .RST_VAL(PIN_RST)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d({wake_input, standby_request, direction_ctrl_a, direction_ctrl_b,
        cs_n, sclk, mosi, fault_in}),
    .q(pin_q)
  );

  // split the synchronised bus back into pins
  assign {wake_s, standby_s, dir_a_s, dir_b_s, cs_s, sclk_s, mosi_s,
          fault_s} = pin_q;

  ////////////////////////////////////////////////////////////////////////////
  // half-bridges

  // wake low overrides, standby high blocks
  assign bridge_en = wake_s && !standby_s;
  // each direction input drives its own half
  assign dir_s = {dir_b_s, dir_a_s};

  // one gate controller per half-bridge
  generate
    for (genvar i = 0; i < 2; i++)
    begin : g_half
      hbsc_half_bridge #(
        .DEAD_CYC(DEAD_CYC)
      ) u_half (
        .clk(clk),
        .rst_n(rst_n),
        .enable(bridge_en),
        .want_high(dir_s[i]),
        .high_on(hs_on[i]),
        .low_on(ls_on[i])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // edge detection and read-back

  // edges from the synchronised level and its delayed copy
  assign sclk_rise = sclk_s && !s_r.sclk_d;
  assign sclk_fall = !sclk_s && s_r.sclk_d;
  assign cs_fall = !cs_s && s_r.cs_d;
  assign cs_rise = cs_s && !s_r.cs_d;
  // interface runs only while awake
  assign active = wake_s && !cs_s;

  // fields of the word held in the shift register
  assign cmd_wr = s_r.sr[HBSC_WR_BIT];
  assign cmd_addr = s_r.sr[HBSC_ADDR_LSB +: HBSC_ADDR_W];

  // register selected by the previous transfer
  always_comb
  begin
    rd_word = '0;
    unique case (s_r.prev_addr)
      HBSC_ADDR_CONFIG:
        rd_word[HBSC_SLEW_LSB +: HBSC_SLEW_W] = s_r.slew;
      HBSC_ADDR_MASK:
        rd_word[HBSC_FAULT_LSB +: FAULT_W] = s_r.mask;
      // status and unused addresses show the live faults
      default:
        rd_word[HBSC_FAULT_LSB +: FAULT_W] = fault_s;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state logic

  always_comb
  begin
    s_nxt = s_r;
    // remember the pin levels for edge detection
    s_nxt.sclk_d = sclk_s;
    s_nxt.cs_d = cs_s;

    if (!wake_s)
    begin
      // asleep: frame state dropped, settings kept
      s_nxt.cnt = '0;
      s_nxt.full = 1'b0;
    end
    else if (cs_fall)
    begin
      // frame start: load the read-back word
      s_nxt.sr = rd_word;
      s_nxt.miso = rd_word[HBSC_WORD_W-1];
      s_nxt.cnt = '0;
      s_nxt.full = 1'b0;
    end
    else if (cs_rise)
    begin
      // frame end on a whole word: commit it
      if (s_r.full && s_r.cnt == '0)
      begin
        s_nxt.prev_addr = cmd_addr;
        if (cmd_wr)
        begin
          unique case (cmd_addr)
            // slew setting for the power stage
            HBSC_ADDR_CONFIG:
              s_nxt.slew = s_r.sr[HBSC_SLEW_LSB +: HBSC_SLEW_W];
            // fault mask
            HBSC_ADDR_MASK:
              s_nxt.mask = s_r.sr[HBSC_FAULT_LSB +: FAULT_W];
            // status is read only
            default:
              s_nxt.mask = s_r.mask;
          endcase
        end
      end
    end
    else if (active && sclk_rise)
    begin
      // present the next bit, msb first
      s_nxt.miso = s_r.sr[HBSC_WORD_W-1];
    end
    else if (active && sclk_fall)
    begin
      // sample mosi into the bottom, msb first
      // after 16 shifts the top holds echoed bits
      s_nxt.sr = {s_r.sr[HBSC_WORD_W-2:0], mosi_s};
      s_nxt.cnt = s_r.cnt + 1'b1;
      if (s_r.cnt == '1)
        s_nxt.full = 1'b1;
    end

    // miso driven only while selected and awake
    s_nxt.miso_oe = active;
    // flag pulled low by unmasked faults only
    s_nxt.fault_lo = 1'b0;
    s_nxt.fault_oe = |(fault_s & s_r.mask);
    // mode indication
    s_nxt.sleep = !wake_s;
    s_nxt.standby = wake_s && standby_s;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= TOP_RST;
    else
      s_r <= s_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, all from flops

  // serial data out
  assign miso_o = s_r.miso;
  assign miso_oe = s_r.miso_oe;
  // open-drain fault flag
  assign fault_flag_n_o = s_r.fault_lo;
  assign fault_flag_n_oe = s_r.fault_oe;
  // gates from the half-bridge controllers
  assign hs_a_on = hs_on[0];
  assign ls_a_on = ls_on[0];
  assign hs_b_on = hs_on[1];
  assign ls_b_on = ls_on[1];
  // mode and slew
  assign sleep_o = s_r.sleep;
  assign standby_o = s_r.standby;
  assign slew_sel_o = s_r.slew;
endmodule

// [verilog/hbsc_pkg.sv]
// hbsc_pkg: constants for the h-bridge spi control logic
// assumes a single 25 MHz clock and a 16-bit spi word
package hbsc_pkg;
  // spi word layout
  localparam int HBSC_WORD_W = 16;
  localparam int HBSC_WR_BIT = 15;
  localparam int HBSC_ADDR_LSB = 13;
  localparam int HBSC_ADDR_W = 2;
  localparam int HBSC_CNT_W = 4;
  // internal register addresses
  localparam logic [1:0] HBSC_ADDR_STATUS = 2'h0;
  localparam logic [1:0] HBSC_ADDR_CONFIG = 2'h1;
  localparam logic [1:0] HBSC_ADDR_MASK = 2'h2;
  // config register: slew select field
  localparam int HBSC_SLEW_LSB = 0;
  localparam int HBSC_SLEW_W = 3;
  localparam logic [2:0] HBSC_SLEW_RST = 3'h2;
  // fault status and mask fields
  localparam int HBSC_FAULT_LSB = 0;
  localparam int HBSC_FAULT_W = 8;
  localparam logic [7:0] HBSC_MASK_RST = 8'hFF;
  // timing
  localparam int HBSC_CLK_NS = 40;
  localparam int HBSC_DEAD_NS = 1000;
  localparam int HBSC_DEAD_CYC = (HBSC_DEAD_NS + HBSC_CLK_NS - 1) / HBSC_CLK_NS;
  localparam int HBSC_DEAD_W = 8;
  // half-bridge drive states, one-hot
  typedef enum logic [2:0]
  {
    HBSC_HB_OFF = 3'b001,
    HBSC_HB_HIGH = 3'b010,
    HBSC_HB_LOW = 3'b100
  } hbsc_hb_t;
endpackage

// [verilog/hbsc_sync.sv]
// hbsc_sync: two-flop synchroniser for a bus of independent levels
// assumes each bit is a slow level or a clock far below clk
`timescale 1ns/1ps
module hbsc_sync
  import hbsc_pkg::*;
#(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // asynchronous in, synchronous out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // both stages of the synchroniser
  typedef struct packed
  {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } hbsc_sync_st_t;

  hbsc_sync_st_t s_r;
  hbsc_sync_st_t s_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // first stage is read only by the second
  always_comb
  begin
    s_nxt.meta = d;
    s_nxt.stable = s_r.meta;
  end

  // register the stages
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= {RST_VAL, RST_VAL};
    else
      s_r <= s_nxt;
  end

  assign q = s_r.stable;
endmodule

// [verilog/hbsc_half_bridge.sv]
// hbsc_half_bridge: gate control of one half-bridge with dead time
// assumes enable and want_high are synchronous to clk
`timescale 1ns/1ps
module hbsc_half_bridge
  import hbsc_pkg::*;
#(
  parameter int DEAD_CYC = HBSC_DEAD_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // requested drive
  input wire logic enable,
  input wire logic want_high,
  // switch gates
  output logic high_on,
  output logic low_on
);
  // drive state, dead-time counter and gate flops
  typedef struct packed
  {
    hbsc_hb_t drive;
    logic [HBSC_DEAD_W-1:0] dead;
    logic high;
    logic low;
  } hbsc_hb_st_t;

  localparam hbsc_hb_st_t HB_RST = '{HBSC_HB_OFF, '0, 1'b0, 1'b0};
  localparam logic [HBSC_DEAD_W-1:0] DEAD_LOAD = HBSC_DEAD_W'(DEAD_CYC);

  hbsc_hb_st_t s_r;
  hbsc_hb_st_t s_nxt;
  hbsc_hb_t target;

  ////////////////////////////////////////////////////////////////////////////
  // move toward the target, always through off plus dead time
  always_comb
  begin
    s_nxt = s_r;
    // disabled means both switches off
    target = !enable ? HBSC_HB_OFF : (want_high ? HBSC_HB_HIGH : HBSC_HB_LOW);
    if (s_r.drive != target && s_r.drive != HBSC_HB_OFF)
    begin
      // leave the old switch first, then wait
      s_nxt.drive = HBSC_HB_OFF;
      s_nxt.dead = DEAD_LOAD;
    end
    else if (s_r.drive == HBSC_HB_OFF)
    begin
      // count the dead time down before any turn-on
      if (s_r.dead != '0)
        s_nxt.dead = s_r.dead - 1'b1;
      else
        s_nxt.drive = target;
    end
    // gates follow the one-hot state, never both on
    s_nxt.high = (s_nxt.drive == HBSC_HB_HIGH);
    s_nxt.low = (s_nxt.drive == HBSC_HB_LOW);
  end

  // register the state
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= HB_RST;
    else
      s_r <= s_nxt;
  end

  assign high_on = s_r.high;
  assign low_on = s_r.low;
endmodule

// [verif/hbsc_spi_host.sv]
// hbsc_spi_host: behavioural spi master for the control block
// assumes sclk idles low and each phase lasts ph clk cycles
`timescale 1ns/1ps
module hbsc_spi_host
(
  // clock
  input wire logic clk,
  // spi pins
  output logic cs_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe
);
  ////////////////////////////////////////
  // idle levels at time zero
  initial
  begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b1;
  end
  // one 32-bit daisy-chain frame, msb first on both lines
  task automatic xfer(input logic [31:0] tx, input int ph,
                      output logic [31:0] rx);
    @(posedge clk);
    cs_n <= 1'b0;
    repeat (8) @(posedge clk);
    for (int i = 31; i >= 0; i--)
    begin
      sclk <= 1'b1;
      mosi <= tx[i];
      repeat (ph) @(posedge clk);
      // sample at the falling edge; released miso reads unknown
      rx[i] = miso_oe ? miso_o : 1'bx;
      sclk <= 1'b0;
      repeat (ph) @(posedge clk);
    end
    cs_n <= 1'b1;
    // released mosi shows the inverse of its last bit
    mosi <= ~tx[0];
    repeat (8) @(posedge clk);
  endtask
endmodule

// [verif/hbsc_control_monitor.sv]
// hbsc_control_monitor: assertions on the control block's ports
// assumes one clk domain and the async active-low rst_n
`timescale 1ns/1ps
module hbsc_control_monitor
  import hbsc_pkg::*;
#(
  parameter int FAULT_W = HBSC_FAULT_W,
  parameter int DEAD_CYC = HBSC_DEAD_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // pins in
  input wire logic wake_input,
  input wire logic standby_request,
  input wire logic direction_ctrl_a,
  input wire logic direction_ctrl_b,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic [FAULT_W-1:0] fault_in,
  // pins out
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic fault_flag_n_o,
  input wire logic fault_flag_n_oe,
  input wire logic hs_a_on,
  input wire logic ls_a_on,
  input wire logic hs_b_on,
  input wire logic ls_b_on,
  input wire logic sleep_o,
  input wire logic standby_o,
  input wire logic [HBSC_SLEW_W-1:0] slew_sel_o
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  logic [7:0] off_cnt_r; // cycles with half a fully off
  logic [7:0] off_cnt_nxt;
  logic gates_on; // any gate on
  // saturating dead-time counter
  always_comb
  begin
    off_cnt_nxt = off_cnt_r;
    gates_on = hs_a_on | ls_a_on | hs_b_on | ls_b_on;
    if (hs_a_on || ls_a_on)
      off_cnt_nxt = 8'h00;
    else if (off_cnt_r != 8'hFF)
      off_cnt_nxt = off_cnt_r + 8'h01;
  end
  // counter register
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      off_cnt_r <= 8'h00;
    else
      off_cnt_r <= off_cnt_nxt;
  end
  ////////////////////////////////////////
  property p_no_shoot;
    !(hs_a_on && ls_a_on) && !(hs_b_on && ls_b_on);
  endproperty
  a_no_shoot: assert property (p_no_shoot)
    else $error("both switches of one half on");
  property p_dead;
    $rose(hs_a_on) || $rose(ls_a_on) |-> off_cnt_r >= DEAD_CYC + 1;
  endproperty
  a_dead: assert property (p_dead)
    else $error("dead time too short");
  property p_sleep;
    sleep_o [*2] |-> !gates_on;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("gate on in sleep");
  property p_stby;
    standby_o [*2] |-> !gates_on;
  endproperty
  a_stby: assert property (p_stby)
    else $error("gate on in standby");
  property p_hiz;
    cs_n [*5] |-> !miso_oe;
  endproperty
  a_hiz: assert property (p_hiz)
    else $error("miso driven while deselected");
  property p_hold;
    (!sclk && !cs_n) [*6] |-> $stable(miso_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("miso moved while sclk low");
  property p_slew;
    $changed(slew_sel_o) |-> cs_n && $past(cs_n, 2);
  endproperty
  a_slew: assert property (p_slew)
    else $error("slew changed inside a frame");
  property p_flag;
    (fault_in == '0) [*5] |-> !fault_flag_n_oe;
  endproperty
  a_flag: assert property (p_flag)
    else $error("flag pulled with no fault");
endmodule
bind hbsc_control hbsc_control_monitor #(.FAULT_W(FAULT_W),
  .DEAD_CYC(DEAD_CYC)) mon_u (.clk(clk), .rst_n(rst_n),
  .wake_input(wake_input), .standby_request(standby_request),
  .direction_ctrl_a(direction_ctrl_a),
  .direction_ctrl_b(direction_ctrl_b), .cs_n(cs_n), .sclk(sclk),
  .mosi(mosi), .fault_in(fault_in), .miso_o(miso_o),
  .miso_oe(miso_oe), .fault_flag_n_o(fault_flag_n_o),
  .fault_flag_n_oe(fault_flag_n_oe), .hs_a_on(hs_a_on),
  .ls_a_on(ls_a_on), .hs_b_on(hs_b_on), .ls_b_on(ls_b_on),
  .sleep_o(sleep_o), .standby_o(standby_o),
  .slew_sel_o(slew_sel_o));

// [verif/tb.sv]
// tb: self-checking bench for the h-bridge spi control logic
// assumes the spi host model and the port monitor are compiled
`timescale 1ns/1ps
module tb;
  import hbsc_pkg::*;
  localparam int DC = 2; // short dead time for simulation
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wake = 1'b0;
  logic stby = 1'b0;
  logic dir_a = 1'b0;
  logic dir_b = 1'b0;
  logic [7:0] flt = 8'h00;
  logic cs_n, sclk, mosi, miso_o, miso_oe, flag_o, flag_oe;
  logic hs_a, ls_a, hs_b, ls_b, slp, stb_o;
  logic [2:0] slew;
  logic [31:0] rx;
  int err_count = 0;
  int samples_checked = 0;
  wire flag_w = flag_oe ? flag_o : 1'b1; // pull-up on the flag
  ////////////////////////////////////////
  always #20 clk = ~clk;
  hbsc_control #(.DEAD_CYC(DC)) dut_u (.clk(clk), .rst_n(rst_n),
    .wake_input(wake), .standby_request(stby),
    .direction_ctrl_a(dir_a), .direction_ctrl_b(dir_b),
    .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso_o(miso_o),
    .miso_oe(miso_oe), .fault_in(flt), .fault_flag_n_o(flag_o),
    .fault_flag_n_oe(flag_oe), .hs_a_on(hs_a), .ls_a_on(ls_a),
    .hs_b_on(hs_b), .ls_b_on(ls_b), .sleep_o(slp),
    .standby_o(stb_o), .slew_sel_o(slew));
  hbsc_spi_host host_u (.clk(clk), .cs_n(cs_n), .sclk(sclk),
    .mosi(mosi), .miso_o(miso_o), .miso_oe(miso_oe));
  ////////////////////////////////////////
  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // wait n clock edges
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // verdict and end of run
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////
  // state after reset, asleep
  task automatic t_reset;
    check(slew, HBSC_SLEW_RST);
    check({slp, miso_oe, hs_a, ls_a, hs_b, ls_b}, 6'h20);
  endtask
  // write slew, status order, echo, read-back
  task automatic t_spi;
    @(posedge clk);
    wake <= 1'b1;
    flt <= 8'h96;
    cyc(6);
    check(slp, 1'b0);
    host_u.xfer(32'h1234A005, 4, rx);
    check(rx[31:16], 16'h0096);
    check(rx[15:0], 16'h1234);
    check(slew, 3'h5);
    host_u.xfer(32'h0000A003, 6, rx);
    check(rx[31:16], 16'h0005);
    check(slew, 3'h3);
  endtask
  // fault flag under the mask
  task automatic t_fault;
    @(posedge clk);
    flt <= 8'h02;
    cyc(6);
    check(flag_w, 1'b0);
    host_u.xfer(32'h0000C001, 4, rx);
    check(flag_w, 1'b1);
    @(posedge clk);
    flt <= 8'h01;
    cyc(6);
    check(flag_w, 1'b0);
    @(posedge clk);
    flt <= 8'h00;
    cyc(6);
    check(flag_w, 1'b1);
  endtask
  // direction steering and reversal
  task automatic t_dir;
    @(posedge clk);
    dir_a <= 1'b1;
    cyc(12);
    check({hs_a, ls_a, hs_b, ls_b}, 4'b1001);
    @(posedge clk);
    dir_a <= 1'b0;
    dir_b <= 1'b1;
    cyc(12);
    check({hs_a, ls_a, hs_b, ls_b}, 4'b0110);
  endtask
  // standby, release, sleep, then a second reset
  task automatic t_modes;
    @(posedge clk);
    stby <= 1'b1;
    cyc(6);
    check({slp, stb_o, hs_a, ls_a, hs_b, ls_b}, 6'h10);
    @(posedge clk);
    stby <= 1'b0;
    cyc(12);
    check({hs_a, ls_a, hs_b, ls_b}, 4'b0110);
    @(posedge clk);
    wake <= 1'b0;
    stby <= 1'b1;
    cyc(6);
    check({slp, hs_a, ls_a, hs_b, ls_b}, 5'h10);
    rst_n <= 1'b0;
    cyc(3);
    rst_n <= 1'b1;
    cyc(2);
    check(slew, HBSC_SLEW_RST);
  endtask
  ////////////////////////////////////////
  // main sequence
  initial
  begin
    cyc(12);
    rst_n <= 1'b1;
    cyc(4);
    t_reset;
    t_spi;
    t_fault;
    t_dir;
    t_modes;
    wrap_up;
  end
  // watchdog, far beyond the expected run
  initial
  begin
    #200000;
    err_count++;
    wrap_up;
  end
endmodule
